// >>> rtl/mfs_supervisor.v
// Behaviour
// - Latched overvoltage response holds switches off until fault clear.
// - Auto overvoltage response recovers once supply is one volt lower.
// - Measurement ramp timeout sets the resistance/inductance fault flag.
// - Low back-EMF during measurement sets the back-EMF fault flag.
// - Position-detect ramps are timed by 12-bit timers.
// - Ramps try 10MHz, then 1MHz, 100kHz, 10kHz timer clocks.
// - Overflow at all four rates on ramp-up raises ramp-up timeout.
// - Overflow at all four rates on ramp-down raises ramp-down timeout.
// - Timeout faults are reported only when the timeout enable is set.
// - New pulse before decay raises pulse-rate fault when enabled.
// - Position faults abort start-up, float switches, retry after lock time.
// - Thermal warning pulls fault pin low, sets flags, keeps running.
// - Pin released below hysteresis; warning flag waits for clear there.
// - Thermal shutdown stops switches and pump, sets three flags.
// - Shutdown recovers by itself; its flag latches until fault clear.
// - Sleep select high enters sleep, disabling switches, analog and bus.
// - Sleep select low idles in standby with pump, regulators, bus on.
// - Analog input enters standby below 1%, exits above 5%.
// - PWM/I2C threshold is max(1%, hysteresis), scaled; else zero.
// - Frequency threshold uses same ratio of max, floor 3Hz.
// - Latched overvoltage holds partial shutdown until fault clear is written.
`timescale 1ns/10ps
`include "mfs_consts.vh"
module mfs_supervisor (
  input wire clock_i, // Core clock, 250 MHz.
  input wire rst_i, // Synchronous reset, active high.
  input wire [11:0] supply_i, // Measured supply code.
  input wire [11:0] overvoltage_level_i, // Overvoltage trip code.
  input wire overvoltage_response_i, // 0 latch, 1 auto recover.
  input wire fault_clear_bit_i, // Fault clear write strobe.
  input wire meas_rl_active_i, // Resistance/inductance measurement on.
  input wire meas_rl_overflow_i, // Measurement pulse timer overflowed.
  input wire meas_bemf_active_i, // Back-EMF constant measurement on.
  input wire [15:0] meas_bemf_i, // Measured back-EMF.
  input wire [15:0] stationary_detect_threshold_i, // Back-EMF floor.
  input wire [1:0] startup_method_i, // Start-up method code.
  input wire pd_rampup_start_i, // Position pulse ramp-up begins.
  input wire pd_rampdown_start_i, // Position pulse ramp-down begins.
  input wire pd_current_reached_i, // Current reached pulse threshold.
  input wire pd_current_zero_i, // Pulse current decayed to zero.
  input wire position_timeout_fault_enable_i, // Timeout fault enable.
  input wire position_pulse_rate_fault_enable_i, // Pulse-rate enable.
  input wire [15:0] lock_retry_time_i, // Retry time in 1 us units.
  input wire thermal_warning_report_enable_i, // Warning report enable.
  input wire temp_warn_i, // Above warning limit.
  input wire temp_warn_hys_i, // Still above warning hysteresis point.
  input wire temp_shut_i, // Above shutdown limit.
  input wire temp_shut_hys_i, // Still above shutdown hysteresis point.
  input wire sleep_select_i, // 1 sleep, 0 standby.
  input wire [1:0] speed_mode_i, // Speed input source.
  input wire ref_profile_zero_i, // Reference profile setting is 00b.
  input wire [15:0] speed_cmd_i, // Speed command, fraction of full scale.
  input wire [15:0] duty_hysteresis_i, // Duty hysteresis fraction.
  input wire [15:0] max_freq_i, // Maximum input frequency in Hz.
  output wire fault_pin_n_o, // Fault pin, low when asserting.
  output reg switches_hiz_o, // All power switches high impedance.
  output reg charge_pump_en_o, // Charge pump enable.
  output reg analog_en_o, // Sense amps and regulators enable.
  output reg bus_en_o, // Serial bus enable.
  output reg run_o, // Motor may run.
  output reg startup_retry_o, // Pulse: retry start-up now.
  output reg overvoltage_flag_o, // Overvoltage fault.
  output reg param_meas_rl_fault_o, // Measurement R/L fault.
  output reg param_meas_backemf_fault_o, // Measurement back-EMF fault.
  output reg position_rampup_timeout_fault_o, // Ramp-up timeout.
  output reg position_rampdown_timeout_fault_o, // Ramp-down timeout.
  output reg position_pulse_rate_fault_o, // Pulse-rate fault.
  output reg thermal_warning_flag_o, // Thermal warning.
  output reg thermal_shutdown_flag_o, // Thermal shutdown seen.
  output reg overtemp_any_flag_o, // Any overtemperature.
  output reg driver_fault_flag_o, // Driver fault.
  output reg sleep_o, // In sleep.
  output reg standby_o // In standby.
);
  localparam ST_RUN = 3'h1;
  localparam ST_IDLE = 3'h2;
  localparam ST_SLEEP = 3'h4;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg warn_pin_ff;
  reg shut_act_ff;
  reg ov_act_ff;
  reg retry_act_ff;
  reg [7:0] us_div_ff;
  reg [15:0] retry_cnt_ff;
  reg pulse_live_ff;
  wire up_to;
  wire dn_done, dn_to;
  wire ipd_on;
  wire pd_fault_ev;
  reg [15:0] thr;
  reg [16:0] thr_scaled;
  reg [31:0] prod;
  reg below_en, above_ex;

  assign ipd_on = (startup_method_i == `MFS_STARTUP_IPD);

  mfs_ramp_timer u_up (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(ipd_on && pd_rampup_start_i && !retry_act_ff),
    .abort_i(retry_act_ff),
    .reached_i(pd_current_reached_i),
    .busy_o(),
    .done_o(),
    .timeout_o(up_to)
  );

  mfs_ramp_timer u_dn (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(ipd_on && pd_rampdown_start_i && !retry_act_ff),
    .abort_i(retry_act_ff),
    .reached_i(pd_current_zero_i),
    .busy_o(),
    .done_o(dn_done),
    .timeout_o(dn_to)
  );

  // A new pulse while the last one still carries current is a rate fault.
  wire rate_ev = position_pulse_rate_fault_enable_i && pd_rampup_start_i &&
                 pulse_live_ff && ipd_on;
  wire up_ev = up_to && position_timeout_fault_enable_i;
  wire dn_ev = dn_to && position_timeout_fault_enable_i;
  assign pd_fault_ev = rate_ev || up_ev || dn_ev;

  // Pulse current is live from ramp-up start until decay is seen.
  always @(posedge clock_i) begin
    if (rst_i)
      pulse_live_ff <= 1'b0;
    else if (pd_rampup_start_i)
      pulse_live_ff <= 1'b1;
    else if (pd_current_zero_i || dn_done)
      pulse_live_ff <= 1'b0;
  end

  // Lock retry timer; a 1 us tick keeps the counter narrow.
  always @(posedge clock_i) begin
    startup_retry_o <= 1'b0;
    if (rst_i) begin
      retry_act_ff <= 1'b0;
      retry_cnt_ff <= 16'h0000;
      us_div_ff <= 8'h00;
    end else if (pd_fault_ev) begin
      retry_act_ff <= 1'b1;
      retry_cnt_ff <= 16'h0000;
      us_div_ff <= 8'h00;
    end else if (retry_act_ff) begin
      if (us_div_ff == 8'hf9) begin
        us_div_ff <= 8'h00;
        if (retry_cnt_ff >= lock_retry_time_i) begin
          retry_act_ff <= 1'b0;
          startup_retry_o <= 1'b1;
        end else begin
          retry_cnt_ff <= retry_cnt_ff + 16'h0001;
        end
      end else begin
        us_div_ff <= us_div_ff + 8'h01;
      end
    end
  end

  // Position and measurement flags; an event wins over a clear.
  always @(posedge clock_i) begin
    if (rst_i) begin
      position_rampup_timeout_fault_o <= 1'b0;
      position_rampdown_timeout_fault_o <= 1'b0;
      position_pulse_rate_fault_o <= 1'b0;
      param_meas_rl_fault_o <= 1'b0;
      param_meas_backemf_fault_o <= 1'b0;
    end else begin
      if (up_ev)
        position_rampup_timeout_fault_o <= 1'b1;
      else if (startup_retry_o || fault_clear_bit_i)
        position_rampup_timeout_fault_o <= 1'b0;
      if (dn_ev)
        position_rampdown_timeout_fault_o <= 1'b1;
      else if (startup_retry_o || fault_clear_bit_i)
        position_rampdown_timeout_fault_o <= 1'b0;
      if (rate_ev)
        position_pulse_rate_fault_o <= 1'b1;
      else if (startup_retry_o || fault_clear_bit_i)
        position_pulse_rate_fault_o <= 1'b0;
      if (meas_rl_active_i && meas_rl_overflow_i)
        param_meas_rl_fault_o <= 1'b1;
      else if (fault_clear_bit_i)
        param_meas_rl_fault_o <= 1'b0;
      if (meas_bemf_active_i && meas_bemf_i < stationary_detect_threshold_i)
        param_meas_backemf_fault_o <= 1'b1;
      else if (fault_clear_bit_i)
        param_meas_backemf_fault_o <= 1'b0;
    end
  end

  // Overvoltage: latched mode waits for clear with supply normal.
  wire ov_trip = (supply_i > overvoltage_level_i);
  wire ov_low = ({1'b0, supply_i} + {1'b0, `MFS_VOLT_CODE}) <
                {1'b0, overvoltage_level_i};
  always @(posedge clock_i) begin
    if (rst_i) begin
      ov_act_ff <= 1'b0;
    end else if (ov_trip) begin
      ov_act_ff <= 1'b1;
    end else if (overvoltage_response_i == `MFS_OV_AUTO) begin
      if (ov_low)
        ov_act_ff <= 1'b0;
    end else if (fault_clear_bit_i) begin
      ov_act_ff <= 1'b0;
    end
  end

  // Thermal latches: pin and shutdown track hysteresis, flags await clear.
  always @(posedge clock_i) begin
    if (rst_i) begin
      warn_pin_ff <= 1'b0;
      shut_act_ff <= 1'b0;
      thermal_warning_flag_o <= 1'b0;
      thermal_shutdown_flag_o <= 1'b0;
      overtemp_any_flag_o <= 1'b0;
      driver_fault_flag_o <= 1'b0;
    end else begin
      if (temp_warn_i && thermal_warning_report_enable_i)
        warn_pin_ff <= 1'b1;
      else if (!temp_warn_hys_i)
        warn_pin_ff <= 1'b0;
      if (temp_warn_i && thermal_warning_report_enable_i)
        thermal_warning_flag_o <= 1'b1;
      else if (fault_clear_bit_i && !temp_warn_hys_i)
        thermal_warning_flag_o <= 1'b0;
      if (temp_shut_i)
        shut_act_ff <= 1'b1;
      else if (!temp_shut_hys_i)
        shut_act_ff <= 1'b0;
      if (temp_shut_i)
        thermal_shutdown_flag_o <= 1'b1;
      else if (fault_clear_bit_i)
        thermal_shutdown_flag_o <= 1'b0;
      if (temp_shut_i || (temp_warn_i && thermal_warning_report_enable_i))
        overtemp_any_flag_o <= 1'b1;
      else if (fault_clear_bit_i && !temp_warn_hys_i && !temp_shut_hys_i)
        overtemp_any_flag_o <= 1'b0;
      if (temp_shut_i)
        driver_fault_flag_o <= 1'b1;
      else if (fault_clear_bit_i && !shut_act_ff)
        driver_fault_flag_o <= 1'b0;
    end
  end

  // Standby threshold per speed mode; in PWM and I2C modes a profile other than 00b gives zero.
  always @* begin
    thr = (duty_hysteresis_i > `MFS_PCT1) ? duty_hysteresis_i : `MFS_PCT1;
    thr_scaled = 17'h00000;
    prod = 32'h00000000;
    below_en = 1'b0;
    above_ex = 1'b0;
    case (speed_mode_i)
      `MFS_SPD_ANALOG: begin
        below_en = speed_cmd_i < `MFS_PCT1;
        above_ex = speed_cmd_i > `MFS_PCT5;
      end
      `MFS_SPD_PWM: begin
        thr_scaled = ref_profile_zero_i ? {1'b0, thr} : 17'h00000;
        below_en = {1'b0, speed_cmd_i} < thr_scaled;
        above_ex = {1'b0, speed_cmd_i} > thr_scaled;
      end
      `MFS_SPD_I2C: begin
        prod = {16'h0000, thr} * {16'h0000, `MFS_I2C_FS};
        thr_scaled = ref_profile_zero_i ? {1'b0, prod[31:16]} : 17'h00000;
        below_en = {1'b0, speed_cmd_i} < thr_scaled;
        above_ex = {1'b0, speed_cmd_i} > thr_scaled;
      end
      default: begin
        prod = {16'h0000, thr} * {16'h0000, max_freq_i};
        thr_scaled = ref_profile_zero_i ? {1'b0, prod[31:16]} : 17'h00000;
        if (thr_scaled < {1'b0, `MFS_FREQ_FLOOR})
          thr_scaled = {1'b0, `MFS_FREQ_FLOOR};
        below_en = {1'b0, speed_cmd_i} < thr_scaled;
        above_ex = {1'b0, speed_cmd_i} >= thr_scaled;
      end
    endcase
  end

  // Power mode state machine.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: if (below_en)
        nxt_state = sleep_select_i ? ST_SLEEP : ST_IDLE;
      ST_IDLE: if (above_ex)
        nxt_state = ST_RUN;
      ST_SLEEP: if (above_ex)
        nxt_state = ST_RUN;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Outputs registered; thermal shutdown also stops the pump.
  always @(posedge clock_i) begin
    if (rst_i) begin
      switches_hiz_o <= 1'b1;
      charge_pump_en_o <= 1'b0;
      analog_en_o <= 1'b0;
      bus_en_o <= 1'b0;
      run_o <= 1'b0;
      overvoltage_flag_o <= 1'b0;
      sleep_o <= 1'b0;
      standby_o <= 1'b0;
    end else begin
      switches_hiz_o <= ov_act_ff || shut_act_ff || retry_act_ff ||
                        pd_fault_ev || (state_ff != ST_RUN);
      charge_pump_en_o <= !shut_act_ff && (state_ff != ST_SLEEP);
      analog_en_o <= (state_ff != ST_SLEEP);
      bus_en_o <= (state_ff != ST_SLEEP);
      run_o <= (state_ff == ST_RUN) && !ov_act_ff && !shut_act_ff &&
               !retry_act_ff;
      overvoltage_flag_o <= ov_act_ff;
      sleep_o <= (state_ff == ST_SLEEP);
      standby_o <= (state_ff == ST_IDLE);
    end
  end

  // Pin low on any active fault or reported warning.
  assign fault_pin_n_o = !(warn_pin_ff || shut_act_ff || ov_act_ff ||
    retry_act_ff || param_meas_rl_fault_o || param_meas_backemf_fault_o);
endmodule // mfs_supervisor

// >>> rtl/mfs_consts.vh
`ifndef MFS_CONSTS_VH
`define MFS_CONSTS_VH
// Overvoltage response codes.
`define MFS_OV_LATCH 1'b0
`define MFS_OV_AUTO 1'b1
// Supply hysteresis for overvoltage auto recovery, in ADC codes per volt.
`define MFS_VOLT_CODE 12'h010
// Start-up method code for position detection.
`define MFS_STARTUP_IPD 2'h2
// Position-detect timer width and its all-ones overflow value.
`define MFS_PT_W 12
`define MFS_PT_MAX 12'hfff
// Clock rates in Hz, and the divider counts at the 250 MHz clock.
`define MFS_CLK_HZ 250000000
`define MFS_R0_HZ 10000000
`define MFS_R1_HZ 1000000
`define MFS_R2_HZ 100000
`define MFS_R3_HZ 10000
`define MFS_DIV0 (`MFS_CLK_HZ / `MFS_R0_HZ)
`define MFS_DIV1 (`MFS_CLK_HZ / `MFS_R1_HZ)
`define MFS_DIV2 (`MFS_CLK_HZ / `MFS_R2_HZ)
`define MFS_DIV3 (`MFS_CLK_HZ / `MFS_R3_HZ)
`define MFS_DIV_W 15
`define MFS_RATES 2'h3
// Speed input modes.
`define MFS_SPD_ANALOG 2'h0
`define MFS_SPD_PWM 2'h1
`define MFS_SPD_I2C 2'h2
`define MFS_SPD_FREQ 2'h3
// Speed thresholds: full scale 16 bits; 1% and 5% as codes.
`define MFS_PCT1 16'h028f
`define MFS_PCT5 16'h0ccc
`define MFS_I2C_FS 16'h7fff
`define MFS_FREQ_FLOOR 16'h0003
`endif

// >>> rtl/mfs_ramp_timer.v
`timescale 1ns/10ps
`include "mfs_consts.vh"
// One ramp measured at four timer rates in turn; reports done or timeout.
module mfs_ramp_timer (
  input wire clock_i, // Core clock.
  input wire rst_i, // Synchronous reset.
  input wire start_i, // Start a ramp attempt sequence.
  input wire abort_i, // Abandon the sequence.
  input wire reached_i, // Current reached its target.
  output reg busy_o, // Sequence in progress.
  output reg done_o, // Target reached, one cycle.
  output reg timeout_o // Overflow at all four rates, one cycle.
);
  reg [`MFS_DIV_W-1:0] div_ff;
  reg [`MFS_PT_W-1:0] tmr_ff;
  reg [1:0] rate_ff;
  wire tick;

  // Divider limit for the current rate; the slowest count fits the width.
  function [`MFS_DIV_W-1:0] div_lim;
    input [1:0] r;
    reg [31:0] lim32;
    begin
      case (r)
        2'h0: lim32 = `MFS_DIV0 - 1;
        2'h1: lim32 = `MFS_DIV1 - 1;
        2'h2: lim32 = `MFS_DIV2 - 1;
        default: lim32 = `MFS_DIV3 - 1;
      endcase
      div_lim = lim32[`MFS_DIV_W-1:0];
    end
  endfunction

  assign tick = (div_ff == div_lim(rate_ff));

  // Each overflow below the slowest rate drops to the next slower rate and retries the ramp.
  always @(posedge clock_i) begin
    done_o <= 1'b0;
    timeout_o <= 1'b0;
    if (rst_i || abort_i) begin
      busy_o <= 1'b0;
      div_ff <= {`MFS_DIV_W{1'b0}};
      tmr_ff <= {`MFS_PT_W{1'b0}};
      rate_ff <= 2'h0;
    end else if (!busy_o) begin
      if (start_i) begin
        busy_o <= 1'b1;
        div_ff <= {`MFS_DIV_W{1'b0}};
        tmr_ff <= {`MFS_PT_W{1'b0}};
        rate_ff <= 2'h0;
      end
    end else if (reached_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b1;
    end else if (tick) begin
      div_ff <= {`MFS_DIV_W{1'b0}};
      if (tmr_ff == `MFS_PT_MAX) begin
        tmr_ff <= {`MFS_PT_W{1'b0}};
        if (rate_ff == `MFS_RATES) begin
          busy_o <= 1'b0;
          timeout_o <= 1'b1;
        end else begin
          rate_ff <= rate_ff + 2'h1;
        end
      end else begin
        tmr_ff <= tmr_ff + {{(`MFS_PT_W-1){1'b0}}, 1'b1};
      end
    end else begin
      div_ff <= div_ff + {{(`MFS_DIV_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // mfs_ramp_timer

// >>> bench/mfs_supervisor_monitor.sv
`timescale 1ns/10ps
// Pin-level checks; every reaction is given at most three edges to show.
module mfs_sup_monitor (
  input wire clock_i, rst_i, // Clock and reset.
  input wire overvoltage_response_i, fault_clear_bit_i, // Controls.
  input wire meas_rl_active_i, meas_rl_overflow_i, meas_bemf_active_i,
  input wire [15:0] meas_bemf_i, stationary_detect_threshold_i,
  input wire position_timeout_fault_enable_i, // Timeout enable.
  input wire thermal_warning_report_enable_i, temp_warn_i, temp_shut_i,
  input wire fault_pin_n_o, switches_hiz_o, charge_pump_en_o, // Power.
  input wire analog_en_o, bus_en_o, overvoltage_flag_o, sleep_o,
  input wire param_meas_rl_fault_o, param_meas_backemf_fault_o,
  input wire position_rampup_timeout_fault_o, thermal_warning_flag_o,
  input wire thermal_shutdown_flag_o, overtemp_any_flag_o, standby_o,
  input wire startup_retry_o, pd_rampup_start_i, // Retry.
  input wire position_rampdown_timeout_fault_o, position_pulse_rate_fault_o,
  input wire driver_fault_flag_o // Driver fault.
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // A latched flag may only drop one or two edges after a clear strobe.
  ov_latch_hold_a: assert property ($fell(overvoltage_flag_o) &&
    !overvoltage_response_i |-> $past(fault_clear_bit_i) ||
    $past(fault_clear_bit_i, 2)) else $error("overvoltage flag lost");
  warn_hold_a: assert property ($fell(thermal_warning_flag_o) |->
    $past(fault_clear_bit_i) || $past(fault_clear_bit_i, 2))
    else $error("warning flag lost");
  shut_hold_a: assert property ($fell(thermal_shutdown_flag_o) |->
    $past(fault_clear_bit_i) || $past(fault_clear_bit_i, 2))
    else $error("shutdown flag lost");
  rl_fault_set_a: assert property (meas_rl_active_i && meas_rl_overflow_i
    |-> ##[1:2] param_meas_rl_fault_o) else $error("rl fault missing");
  bemf_fault_set_a: assert property (meas_bemf_active_i &&
    meas_bemf_i < stationary_detect_threshold_i |-> ##[1:2]
    param_meas_backemf_fault_o) else $error("back-emf fault missing");
  timeout_gate_a: assert property ($rose(position_rampup_timeout_fault_o)
    |-> $past(position_timeout_fault_enable_i)) else $error("ungated");
  warn_report_a: assert property (temp_warn_i &&
    thermal_warning_report_enable_i |-> ##[1:2] (thermal_warning_flag_o
    && overtemp_any_flag_o && !fault_pin_n_o)) else $error("no warning");
  shut_flags_a: assert property (temp_shut_i |-> ##[1:2]
    (thermal_shutdown_flag_o && overtemp_any_flag_o && driver_fault_flag_o
    && !fault_pin_n_o)) else $error("shutdown flags missing");
  shut_power_a: assert property (temp_shut_i |-> ##[1:3]
    (switches_hiz_o && !charge_pump_en_o)) else $error("power still on");
  sleep_off_a: assert property (sleep_o && $past(sleep_o, 2) |->
    switches_hiz_o && !charge_pump_en_o && !analog_en_o && !bus_en_o)
    else $error("sleep left blocks on");
  standby_on_a: assert property (standby_o && $past(standby_o, 2) |->
    analog_en_o && bus_en_o) else $error("standby blocks off");
  retry_clear_a: assert property (startup_retry_o &&
    !pd_rampup_start_i |=> !position_pulse_rate_fault_o &&
    !position_rampup_timeout_fault_o && !position_rampdown_timeout_fault_o)
    else $error("retry left position flags");
endmodule // mfs_sup_monitor

bind mfs_supervisor mfs_sup_monitor i_mon (.*);

// >>> bench/mfs_ctrl_model.sv
`timescale 1ns/10ps
// External controller: writes fault clears and holds the speed command.
module mfs_ctrl_model (
  input wire clock_i, // Core clock.
  input wire rst_i, // Synchronous reset.
  input wire clear_req_i, // Ask for one fault clear write.
  input wire slow_i, // Answer late instead of at once.
  input wire speed_req_i, // Load a new speed command.
  input wire [15:0] speed_val_i, // Speed command to load.
  output reg fault_clear_bit_o, // One-cycle clear write.
  output reg [15:0] speed_cmd_o // Held speed command.
);
  reg [3:0] wait_ff;
  // The clear is a single strobe, so a fault still present is never
  // wiped by a bit left high.
  always @(posedge clock_i) begin
    if (rst_i) begin
      wait_ff <= 4'h0;
      fault_clear_bit_o <= 1'b0;
      speed_cmd_o <= 16'h0;
    end else begin
      fault_clear_bit_o <= (wait_ff == 4'h1);
      if (clear_req_i)
        wait_ff <= slow_i ? 4'h9 : 4'h1;
      else if (wait_ff != 4'h0)
        wait_ff <= wait_ff - 4'h1;
      if (speed_req_i)
        speed_cmd_o <= speed_val_i;
    end
  end
endmodule // mfs_ctrl_model

// >>> bench/test_mfs_supervisor.sv
`timescale 1ns/10ps
`include "mfs_consts.vh"
`define CHK(a, b) checked++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end
module test_mfs_supervisor;
  logic clock_i, rst_i, overvoltage_response_i, meas_rl_active_i;
  logic meas_rl_overflow_i, meas_bemf_active_i, pd_rampup_start_i;
  logic pd_rampdown_start_i, pd_current_reached_i, pd_current_zero_i;
  logic position_timeout_fault_enable_i, position_pulse_rate_fault_enable_i;
  logic thermal_warning_report_enable_i, temp_warn_i, temp_warn_hys_i;
  logic temp_shut_i, temp_shut_hys_i, sleep_select_i, ref_profile_zero_i;
  logic [11:0] supply_i, overvoltage_level_i;
  logic [15:0] meas_bemf_i, stationary_detect_threshold_i, lock_retry_time_i;
  logic [15:0] duty_hysteresis_i, max_freq_i, spd_val;
  logic [1:0] startup_method_i, speed_mode_i;
  logic clr_req, slow, spd_req, look;
  wire fault_clear_bit_i, fault_pin_n_o, switches_hiz_o, charge_pump_en_o;
  wire analog_en_o, bus_en_o, run_o, startup_retry_o, overvoltage_flag_o;
  wire param_meas_rl_fault_o, param_meas_backemf_fault_o, sleep_o, standby_o;
  wire position_rampup_timeout_fault_o, position_rampdown_timeout_fault_o;
  wire position_pulse_rate_fault_o, thermal_warning_flag_o;
  wire thermal_shutdown_flag_o, overtemp_any_flag_o, driver_fault_flag_o;
  wire [15:0] speed_cmd_i;
  logic [31:0] note_q[$];
  logic [31:0] note;
  logic [31:0] seed = 32'hfd6db9c9;
  logic [15:0] hi_v[4] = '{`MFS_PCT5 + 16'h1, 16'h1100, 16'h0900, 16'd80};
  logic [15:0] lo_v[4] = '{`MFS_PCT1 - 16'h1, 16'h0f00, 16'h0700, 16'd50};
  int errors = 0;
  int checked = 0;
  // Observed outputs packed for masked comparison.
  wire [15:0] obs = {fault_pin_n_o, switches_hiz_o, charge_pump_en_o,
    analog_en_o, bus_en_o, run_o, overvoltage_flag_o, param_meas_rl_fault_o,
    param_meas_backemf_fault_o, position_rampup_timeout_fault_o,
    position_rampdown_timeout_fault_o, position_pulse_rate_fault_o,
    thermal_warning_flag_o, thermal_shutdown_flag_o, sleep_o, standby_o};

  mfs_supervisor i_dut (.*);
  mfs_ctrl_model i_ctrl (.clock_i(clock_i), .rst_i(rst_i),
    .clear_req_i(clr_req), .slow_i(slow), .speed_req_i(spd_req),
    .speed_val_i(spd_val), .fault_clear_bit_o(fault_clear_bit_i),
    .speed_cmd_o(speed_cmd_i));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Notes the expected outputs; the watcher compares one edge later.
  task automatic expect_obs(input logic [15:0] m, input logic [15:0] v);
    note_q.push_back({m, v});
    look <= 1'b1;
    @(posedge clock_i);
    look <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic clear_faults(input logic s);
    slow <= s;
    clr_req <= 1'b1;
    @(posedge clock_i);
    clr_req <= 1'b0;
    cyc(14);
  endtask
  task automatic set_speed(input logic [15:0] v);
    spd_val <= v;
    spd_req <= 1'b1;
    @(posedge clock_i);
    spd_req <= 1'b0;
    cyc(8);
  endtask
  task tally_and_finish;
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watcher takes the oldest note whenever a look is due.
  always @(posedge clock_i) begin
    if (look === 1'b1) begin
      note = note_q.pop_front();
      `CHK(obs & note[31:16], note[15:0])
    end
  end
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // The whole sequence needs well under 2000 cycles.
  initial begin
    cyc(20000);
    errors++;
    tally_and_finish;
  end
  initial begin
    {overvoltage_response_i, meas_rl_active_i, meas_rl_overflow_i} = '0;
    {meas_bemf_active_i, pd_rampup_start_i, pd_rampdown_start_i} = '0;
    {pd_current_reached_i, pd_current_zero_i, startup_method_i} = '0;
    {position_timeout_fault_enable_i, position_pulse_rate_fault_enable_i} = '0;
    {temp_warn_i, temp_warn_hys_i, temp_shut_i, temp_shut_hys_i} = '0;
    {sleep_select_i, ref_profile_zero_i, speed_mode_i, look} = '0;
    {thermal_warning_report_enable_i, clr_req, slow, spd_req} = '0;
    {meas_bemf_i, lock_retry_time_i, duty_hysteresis_i, spd_val} = '0;
    stationary_detect_threshold_i = 16'h0200;
    overvoltage_level_i = 12'h200;
    supply_i = 12'h100;
    max_freq_i = 16'd1000;
    rst_i = 1'b1;
    cyc(5);
    rst_i <= 1'b0;
    cyc(3);
    expect_obs(16'hc3fc, 16'hc000);
    supply_i <= 12'h210;
    cyc(4);
    expect_obs(16'h4200, 16'h4200);
    supply_i <= 12'h100 + 12'(xs() % 32'h0ff);
    cyc(4);
    expect_obs(16'h0200, 16'h0200);
    clear_faults(1'b1);
    expect_obs(16'h0200, 16'h0000);
    overvoltage_response_i <= 1'b1;
    supply_i <= 12'h210;
    cyc(4);
    expect_obs(16'h0200, 16'h0200);
    supply_i <= 12'h1f8;
    cyc(4);
    expect_obs(16'h0200, 16'h0200);
    supply_i <= 12'h1ec;
    cyc(4);
    expect_obs(16'h0200, 16'h0000);
    // Back-emf above the floor and a clean measurement raise nothing.
    {meas_rl_active_i, meas_bemf_active_i} <= 2'h3;
    meas_bemf_i <= 16'h0200 + 16'(xs() % 32'h7fff);
    cyc(3);
    expect_obs(16'h0180, 16'h0000);
    meas_rl_overflow_i <= 1'b1;
    meas_bemf_i <= 16'h01ff;
    cyc(1);
    {meas_rl_active_i, meas_bemf_active_i, meas_rl_overflow_i} <= 3'h0;
    cyc(3);
    expect_obs(16'h0180, 16'h0180);
    clear_faults(1'b0);
    expect_obs(16'h0180, 16'h0000);
    thermal_warning_report_enable_i <= 1'b1;
    {temp_warn_i, temp_warn_hys_i} <= 2'h3;
    cyc(3);
    expect_obs(16'h8008, 16'h0008);
    temp_warn_i <= 1'b0;
    clear_faults(1'b0);
    expect_obs(16'h8008, 16'h0008);
    temp_warn_hys_i <= 1'b0;
    cyc(3);
    expect_obs(16'h8008, 16'h8008);
    clear_faults(1'b0);
    expect_obs(16'h8008, 16'h8000);
    {temp_shut_i, temp_shut_hys_i} <= 2'h3;
    cyc(4);
    expect_obs(16'he004, 16'h4004);
    {temp_shut_i, temp_shut_hys_i} <= 2'h0;
    cyc(4);
    expect_obs(16'h8004, 16'h8004);
    clear_faults(1'b0);
    expect_obs(16'h0004, 16'h0000);
    // Ramps that complete at once raise no position fault.
    startup_method_i <= `MFS_STARTUP_IPD;
    {position_timeout_fault_enable_i, position_pulse_rate_fault_enable_i} <= 2'h3;
    {pd_current_reached_i, pd_current_zero_i} <= 2'h3;
    lock_retry_time_i <= 16'(xs() % 32'h4);
    pd_rampup_start_i <= 1'b1;
    cyc(1);
    pd_rampup_start_i <= 1'b0;
    cyc(4);
    pd_rampdown_start_i <= 1'b1;
    cyc(1);
    pd_rampdown_start_i <= 1'b0;
    cyc(4);
    expect_obs(16'h0070, 16'h0000);
    // A second pulse while current still flows trips the rate fault.
    pd_current_zero_i <= 1'b0;
    repeat (2) begin
      pd_rampup_start_i <= 1'b1;
      cyc(1);
      pd_rampup_start_i <= 1'b0;
      cyc(2);
    end
    expect_obs(16'h8010, 16'h0010);
    pd_current_zero_i <= 1'b1;
    cyc(1020);
    expect_obs(16'h8010, 16'h8000);
    ref_profile_zero_i <= 1'b1;
    duty_hysteresis_i <= 16'h1000;
    for (int i = 0; i < 4; i++) begin
      speed_mode_i <= 2'(i);
      set_speed(hi_v[i]);
      expect_obs(16'h4401, 16'h0400);
      if (i == 0) begin
        set_speed(`MFS_PCT1 + 16'h1 + 16'(xs() % 32'h0a3b));
        expect_obs(16'h0001, 16'h0000);
      end
      set_speed(lo_v[i]);
      expect_obs(16'h0001, 16'h0001);
    end
    expect_obs(16'h3801, 16'h3801);
    sleep_select_i <= 1'b1;
    set_speed(hi_v[3]);
    set_speed(16'h0);
    cyc(20);
    expect_obs(16'h7802, 16'h4002);
    cyc(3);
    tally_and_finish;
  end
endmodule // test_mfs_supervisor
